// [tb_top.sv]
// self-checking bench for the thermostat result and alarm block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    localparam int CONV = 20;
    localparam logic [6:0] DEV = {tra_pkg::ADDR_UPPER, 3'h5};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] sensorValue = 12'h0;
    logic sclClk, sdaIn, sdaOut, sdaOe_n, alarmOut, alarmOe_n, nak, s;
    logic [15:0] d, mask;
    int n_fail = 0;
    int checks_done = 0;
    int t, q;

    tra_top #(.CONV_CYCLES(CONV)) dut (.clk(clk), .rst(rst), .sclClk(sclClk), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addrSel(3'h5), .sensorValue(sensorValue),
        .alarmOut(alarmOut), .alarmOe_n(alarmOe_n));
    tra_master m (.sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [1:0] p, input logic [15:0] v);
        m.wr(DEV, p, v, nak);
        `CHK("ack", 1'b0, nak)
    endtask
    // pointer is only set by the pointer byte of a write, so rreg writes the pointer before reading
    task automatic rreg(input logic [1:0] p, input logic [15:0] v);
        wreg(p, v);
        m.rd(DEV, d, nak);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        finish_test();
    end

    initial begin
        // link flops see two edges under reset while the core sees three
        fork
            repeat (2) m.clk1(1'b1, s);
        join_none
        cyc(3);
        rst = 1'b0;
        cyc(1);
        `CHK("pol", 1'b0, alarmOut)
        sensorValue = 12'h510;
        cyc(4 * CONV);
        `CHK("trip", 1'b0, alarmOe_n)
        sensorValue = 12'h4C0;
        cyc(3 * CONV);
        `CHK("hold", 1'b0, alarmOe_n)
        sensorValue = 12'h400;
        cyc(4 * CONV);
        `CHK("clear", 1'b1, alarmOe_n)
        rreg(tra_pkg::PTR_OVER, 16'hA5C3);
        `CHK("over", 16'hA5C3, d)
        rreg(tra_pkg::PTR_HYST, 16'h5A3C);
        `CHK("hyst", 16'h5A3C, d)
        wreg(tra_pkg::PTR_OVER, tra_pkg::OVER_RESET);
        wreg(tra_pkg::PTR_HYST, tra_pkg::HYST_RESET);
        for (int r = 0; r < 4; r++) begin
            cyc(1);
            sensorValue = r[0] ? 12'hE6F : 12'h191;
            rreg(tra_pkg::PTR_CONFIG, {1'b0, r[1:0], 5'h0, 8'h0});
            `CHK("cfg", {1'b0, r[1:0], 5'h0}, d[15:8])
            cyc(3 * CONV);
            rreg(tra_pkg::PTR_RESULT, 16'hFFFF);
            mask = ~((16'h0010 << (3 - r)) - 16'h1);
            `CHK("result", {sensorValue, 4'h0} & mask, d)
            m.rd(DEV, d, nak);
            `CHK("reread", {sensorValue, 4'h0} & mask, d)
        end
        for (int f = 0; f < 4; f++) begin
            sensorValue = 12'h400;
            wreg(tra_pkg::PTR_CONFIG, {3'h0, f[1:0], 3'h0, 8'h0});
            cyc(7 * CONV);
            sensorValue = 12'h510;
            q = (f == 3) ? 6 : (1 << f);
            t = 0;
            while (alarmOe_n && t < 200) begin
                cyc(1);
                t++;
            end
            `CHK("queue", 1'b1, t >= (q - 1) * CONV && t <= (q + 1) * CONV + 8)
        end
        sensorValue = 12'h400;
        wreg(tra_pkg::PTR_CONFIG, 16'h0200);
        cyc(7 * CONV);
        // the hysteresis crossing may have raised it; a read starts from idle
        m.rd(DEV, d, nak);
        cyc(10);
        `CHK("int idle", 1'b1, alarmOe_n)
        sensorValue = 12'h510;
        cyc(3 * CONV);
        `CHK("int set", 1'b0, alarmOe_n)
        cyc(2 * CONV);
        `CHK("int hold", 1'b0, alarmOe_n)
        m.rd(DEV, d, nak);
        cyc(10);
        `CHK("read clr", 1'b1, alarmOe_n)
        cyc(2 * CONV);
        `CHK("stay clr", 1'b1, alarmOe_n)
        sensorValue = 12'h400;
        cyc(3 * CONV);
        `CHK("re-arm", 1'b0, alarmOe_n)
        wreg(tra_pkg::PTR_CONFIG, 16'h0300);
        cyc(10);
        `CHK("sd clr", 1'b1, alarmOe_n)
        wreg(tra_pkg::PTR_CONFIG, 16'h0500);
        cyc(10);
        `CHK("pol hi", 1'b1, alarmOut)
        `CHK("released", 1'b1, alarmOe_n)
        sensorValue = 12'h100;
        wreg(tra_pkg::PTR_CONFIG, 16'h0000);
        cyc(3 * CONV);
        wreg(tra_pkg::PTR_CONFIG, 16'h0100);
        cyc(3 * CONV);
        sensorValue = 12'h191;
        cyc(3 * CONV);
        rreg(tra_pkg::PTR_RESULT, 16'h0);
        `CHK("sd keep", 16'h1000, d)
        wreg(tra_pkg::PTR_CONFIG, 16'h8100);
        cyc(3 * CONV);
        sensorValue = 12'h0A2;
        rreg(tra_pkg::PTR_RESULT, 16'h0);
        `CHK("one shot", 16'h1900, d)
        cyc(3 * CONV);
        m.rd(DEV, d, nak);
        `CHK("back down", 16'h1900, d)
        m.wr({tra_pkg::ADDR_UPPER, 3'h4}, tra_pkg::PTR_OVER, 16'h1111, nak);
        `CHK("foreign", 1'b1, nak)
        m.rd(DEV, d, nak);
        `CHK("ptr kept", 16'h1900, d)
        finish_test();
    end
endmodule

// [tra_master.sv]
// two-wire bus master model; clock stands low between frames
`timescale 1ns/100ps
module tra_master (
    // link clock and data
    output logic sclClk,
    output logic sdaIn,
    // device side of the data line
    input wire logic sdaOut,
    input wire logic sdaOe_n
);
    logic drv = 1'b1;
    initial sclClk = 1'b0;
    // pull-up: line high unless someone pulls it
    assign sdaIn = drv & (sdaOe_n | sdaOut);

    // one link clock; the bench period is a scaled stand-in for the master rate
    task automatic clk1(input logic b, output logic s);
        drv = b;
        #3 sclClk = 1'b1;
        s = sdaIn;
        #3 sclClk = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) clk1(tx[i], rx[i]);
        clk1(ackIn, ack);
    endtask

    task automatic wr(input logic [6:0] adr, input logic [1:0] p, input logic [15:0] d,
                      output logic nak);
        logic [7:0] rx;
        logic a;
        xfer({adr, 1'b0}, 1'b1, rx, nak);
        xfer({6'h0, p}, 1'b1, rx, a);
        xfer(d[15:8], 1'b1, rx, a);
        xfer(d[7:0], 1'b1, rx, a);
        #30;
    endtask

    task automatic rd(input logic [6:0] adr, output logic [15:0] d, output logic nak);
        logic [7:0] rx;
        logic a;
        xfer({adr, 1'b1}, 1'b1, rx, nak);
        xfer(8'hFF, 1'b0, d[15:8], a);
        xfer(8'hFF, 1'b1, d[7:0], a);
        #30;
    endtask
endmodule

// [tra_monitor.sv]
// assertion checker on the thermostat block pins
`timescale 1ns/100ps
module tra_monitor #(
    parameter int CONV_CYCLES = tra_pkg::CONV_CYCLES
) (
    // clocks and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic sclClk,
    // link pins
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe_n,
    input wire logic [2:0] addrSel,
    // sensor and alarm
    input wire logic [11:0] sensorValue,
    input wire logic alarmOut,
    input wire logic alarmOe_n
);
    // margin covers conversion phase plus two extra conversions of latency
    localparam int TRIP = 3 * CONV_CYCLES + 10;
    logic quiet_q;
    logic [15:0] age_q, hot_q, warm_q, cold_q;

    function automatic logic [15:0] run(input logic [15:0] c, input logic cond);
        return cond ? ((c < 16'hFFFF) ? c + 16'h1 : c) : 16'h0;
    endfunction

    // link sampled on the core clock; a full byte cannot slip past
    always_ff @(posedge clk) begin
        if (rst) begin
            quiet_q <= 1'b1;
            age_q <= 16'h0;
            hot_q <= 16'h0;
            warm_q <= 16'h0;
            cold_q <= 16'h0;
        end else begin
            quiet_q <= quiet_q & ~sclClk;
            age_q <= run(age_q, 1'b1);
            hot_q <= run(hot_q, $signed(sensorValue) >= 12'sh508);
            warm_q <= run(warm_q, $signed(sensorValue) >= 12'sh4B0);
            cold_q <= run(cold_q, $signed(sensorValue) < 12'sh4B0);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_reset_idle: assert property ($fell(rst) |-> alarmOe_n && !alarmOut)
        else $error("alarm not idle after reset");
    chk_default_low: assert property (quiet_q |-> !alarmOut)
        else $error("alarm level not active low by default");
    chk_sda_low: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
    chk_early_trip: assert property (!alarmOe_n |-> age_q >= CONV_CYCLES)
        else $error("alarm before first conversion");
    chk_lone_trip: assert property (quiet_q && hot_q >= TRIP && age_q >= TRIP |-> !alarmOe_n)
        else $error("standalone alarm missing");
    chk_comp_hold: assert property (quiet_q && warm_q >= TRIP && !alarmOe_n |=> !alarmOe_n)
        else $error("alarm dropped above hysteresis");
    chk_cold_idle: assert property (quiet_q && cold_q >= TRIP |-> alarmOe_n)
        else $error("alarm held below hysteresis");
    chk_link_idle: assert property (quiet_q |-> sdaOe_n)
        else $error("data line pulled without traffic");
endmodule

bind tra_top tra_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (
    .clk(clk),
    .rst(rst),
    .sclClk(sclClk),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n),
    .addrSel(addrSel),
    .sensorValue(sensorValue),
    .alarmOut(alarmOut),
    .alarmOe_n(alarmOe_n)
);

// [tra_pkg.sv]
// shared constants and types for the thermostat result and alarm block
package tra_pkg;
    // register pointer codes
    localparam logic [1:0] PTR_RESULT = 2'h0;
    localparam logic [1:0] PTR_CONFIG = 2'h1;
    localparam logic [1:0] PTR_HYST = 2'h2;
    localparam logic [1:0] PTR_OVER = 2'h3;
    // configuration bit positions
    localparam int CFG_SHUTDOWN = 0;
    localparam int CFG_INTMODE = 1;
    localparam int CFG_POLARITY = 2;
    localparam int CFG_FAULT_LO = 3;
    localparam int CFG_FAULT_HI = 4;
    localparam int CFG_RES_LO = 5;
    localparam int CFG_RES_HI = 6;
    localparam int CFG_SINGLE = 7;
    // power-up values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [15:0] OVER_RESET = 16'h5000;
    localparam logic [15:0] HYST_RESET = 16'h4B00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // bus address upper bits, fixed; low three bits come from the strap pins
    localparam logic [3:0] ADDR_UPPER = 4'h9;
    // fastest link rate and derived glitch filter length on the core clock
    localparam int LINK_MAX_KHZ = 400;
    localparam int CORE_MHZ = 250;
    localparam int CONV_CYCLES = 1000;
    localparam int SER_FILTER = 3;

    typedef struct packed {
        logic singleShot;
        logic [1:0] resolution;
        logic [1:0] faultCount;
        logic polarity;
        logic intMode;
        logic shutdown;
    } tra_cfg_t;

    typedef struct packed {
        logic wrValid;
        logic [1:0] wrPtr;
        logic [15:0] wrData;
        logic rdStrobe;
    } tra_bus_t;
endpackage

// [tra_serial.sv]
// two-wire slave on the link clock: address match, pointer, reads and writes
`timescale 1ns/100ps
module tra_serial (
    // link clock and reset
    input wire logic sclClk,
    input wire logic rst,
    // link pins
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    input wire logic [2:0] addrSel,
    // register view, already crossed into this domain
    input wire logic [15:0] rdWord,
    output logic [1:0] ptr,
    // write event: toggle with held word
    output logic wrToggle,
    output logic [1:0] wrPtr,
    output logic [15:0] wrData,
    // read event toggle
    output logic rdToggle
);
    logic addrMatch;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [1:0] byteIdx_q;
    logic active_q;
    logic reading_q;
    logic ackPhase_q;
    logic [15:0] txWord_q;

    // full address byte stands in shift_q through the ack slot
    assign addrMatch = shift_q[7:1] == {tra_pkg::ADDR_UPPER, addrSel};

    // all of this runs on the link clock itself, so any master rate works
    always_ff @(posedge sclClk) begin
        if (rst) begin
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            byteIdx_q <= 2'h0;
            active_q <= 1'b0;
            reading_q <= 1'b0;
            ackPhase_q <= 1'b0;
            ptr <= 2'h0;
            wrToggle <= 1'b0;
            wrPtr <= 2'h0;
            wrData <= 16'h0000;
            rdToggle <= 1'b0;
            txWord_q <= 16'h0000;
        end else if (ackPhase_q) begin
            ackPhase_q <= 1'b0;
            bitCnt_q <= 4'h0;
            if (byteIdx_q == 2'h0) begin
                // address byte: upper bits fixed, low three from straps
                active_q <= addrMatch;
                reading_q <= shift_q[0];
                if (shift_q[0] && addrMatch) begin
                    txWord_q <= rdWord;
                    rdToggle <= ~rdToggle;
                end
            end
            // no stop detection: a read frame is three bytes, a write frame four
            if (reading_q && byteIdx_q == 2'h2) begin
                byteIdx_q <= 2'h0;
                reading_q <= 1'b0;
            end else begin
                byteIdx_q <= byteIdx_q + 2'h1;
            end
        end else begin
            shift_q <= {shift_q[6:0], sdaIn};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (reading_q) txWord_q <= {txWord_q[14:0], 1'b0};
            if (bitCnt_q == 4'h7) begin
                ackPhase_q <= 1'b1;
                if (active_q && !reading_q) begin
                    if (byteIdx_q == 2'h1) ptr <= {shift_q[0], sdaIn};
                    if (byteIdx_q == 2'h2) wrData[15:8] <= {shift_q[6:0], sdaIn};
                    if (byteIdx_q == 2'h3) begin
                        wrData[7:0] <= {shift_q[6:0], sdaIn};
                        wrPtr <= ptr;
                        wrToggle <= ~wrToggle;
                    end
                end
            end
        end
    end

    // open drain: enable low while pulling sda low
    assign sdaOut = 1'b0;
    // in a read the master owns the data-byte ack slots, so the line is released there
    assign sdaOe_n = ackPhase_q ? !((byteIdx_q == 2'h0) ? addrMatch : (active_q && !reading_q)) :
                     (reading_q && active_q) ? txWord_q[15] : 1'b1;
endmodule

// [tra_sync.sv]
// two-flop level synchroniser
`timescale 1ns/100ps
module tra_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// [tra_top.sv]
// thermostat result store, threshold compare, fault queue and alarm pin
// Functional notes
// - each finished conversion stores a 16-bit two's complement result, bit 15 sign.
// - result bits 3 to 0 always read zero.
// - result left aligned; unused low bits below resolution read zero.
// - resolution selectable 9, 10, 11 or 12 bits.
// - power-up selects 9 bits and converts continuously without bus access.
// - result reads return last completed value and never disturb conversion.
// - after each conversion compare against thresholds and update alarm by mode.
// - compare only as many upper threshold bits as the resolution.
// - fault queue; alarm trips only after programmed consecutive faults.
// - fault code 00,01,10,11 means 1,2,4,6 faults; defaults zero.
// - single conversion mode measures once, stores, returns to shutdown.
// - alarm active level follows polarity bit; default active low.
// - power-up defaults run the thermostat with no bus traffic.
// - three strap pins give the low three address bits.
// - link works at any rate up to 400 kHz.
// - overlimit and hysteresis are 16-bit read/write general storage too.
// - comparator mode alarm holds until value falls below hysteresis.
// - interrupt mode alarm clears only by shutdown or any register read.
`timescale 1ns/100ps
module tra_top #(
    parameter int CONV_CYCLES = tra_pkg::CONV_CYCLES
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    // address straps
    input wire logic [2:0] addrSel,
    // converter sample, full 12-bit signed value in sixteenths
    input wire logic [11:0] sensorValue,
    // alarm pin, tri-state: drives the polarity level while asserted
    output logic alarmOut,
    output logic alarmOe_n
);
    tra_pkg::tra_cfg_t cfg_q;
    logic [15:0] result_q;
    logic [15:0] over_q;
    logic [15:0] hyst_q;
    logic [15:0] rdWordCore;
    logic [15:0] rdWordLink;
    logic [1:0] ptrLink;
    logic [1:0] ptrCore;
    logic [2:0] addrLink;
    logic wrTogLink;
    logic [1:0] wrPtrLink;
    logic [15:0] wrDataLink;
    logic rdTogLink;
    logic wrTogSync;
    logic rdTogSync;
    logic wrTogPrev_q;
    logic rdTogPrev_q;
    logic wrEvent;
    logic rdEvent;
    logic [1:0] wrPtr_q;
    logic [15:0] wrData_q;
    logic [11:0] sensorSync;
    logic [31:0] convCnt_q;
    logic convDone;
    logic running;
    logic [15:0] sample;
    logic [15:0] resMask;
    logic overHit;
    logic underHit;
    logic [2:0] faultRun_q;
    logic [2:0] faultNeed;
    logic alarm_q;
    logic armedHigh_q;

    // keep the largest mask (fewest bits kept) for 9-bit mode
    function automatic logic [15:0] res_mask(input logic [1:0] res);
        case (res)
            2'h0: res_mask = 16'hFF80;
            2'h1: res_mask = 16'hFFC0;
            2'h2: res_mask = 16'hFFE0;
            default: res_mask = 16'hFFF0;
        endcase
    endfunction

    function automatic logic [2:0] fault_need(input logic [1:0] code);
        case (code)
            2'h0: fault_need = 3'h1;
            2'h1: fault_need = 3'h2;
            2'h2: fault_need = 3'h4;
            default: fault_need = 3'h6;
        endcase
    endfunction

    tra_serial u_serial (
        .sclClk(sclClk),
        .rst(rst),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n),
        .addrSel(addrLink),
        .rdWord(rdWordLink),
        .ptr(ptrLink),
        .wrToggle(wrTogLink),
        .wrPtr(wrPtrLink),
        .wrData(wrDataLink),
        .rdToggle(rdTogLink)
    );

    // link-side words are held stable after each toggle, so sampling after sync is safe
    tra_sync #(.WIDTH(2)) u_syncTog (
        .clk(clk),
        .rst(rst),
        .din({wrTogLink, rdTogLink}),
        .dout({wrTogSync, rdTogSync})
    );

    tra_sync #(.WIDTH(14)) u_syncIn (
        .clk(clk),
        .rst(rst),
        .din({sensorValue, ptrLink}),
        .dout({sensorSync, ptrCore})
    );

    // strap pins cross into the link domain like any other pin
    tra_sync #(.WIDTH(3)) u_syncAddr (
        .clk(sclClk),
        .rst(rst),
        .din(addrSel),
        .dout(addrLink)
    );

    // read word goes back to the link: two flops on the link clock
    tra_sync #(.WIDTH(16)) u_syncRd (
        .clk(sclClk),
        .rst(rst),
        .din(rdWordCore),
        .dout(rdWordLink)
    );

    assign wrEvent = wrTogSync ^ wrTogPrev_q;
    assign rdEvent = rdTogSync ^ rdTogPrev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            wrTogPrev_q <= 1'b0;
            rdTogPrev_q <= 1'b0;
            wrPtr_q <= 2'h0;
            wrData_q <= 16'h0000;
        end else begin
            wrTogPrev_q <= wrTogSync;
            rdTogPrev_q <= rdTogSync;
            wrPtr_q <= wrPtrLink;
            wrData_q <= wrDataLink;
        end
    end

    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= tra_pkg::CONFIG_RESET;
            over_q <= tra_pkg::OVER_RESET;
            hyst_q <= tra_pkg::HYST_RESET;
        end else begin
            if (wrEvent && wrPtr_q == tra_pkg::PTR_CONFIG) cfg_q <= wrData_q[15:8];
            if (wrEvent && wrPtr_q == tra_pkg::PTR_OVER) over_q <= wrData_q;
            if (wrEvent && wrPtr_q == tra_pkg::PTR_HYST) hyst_q <= wrData_q;
            // one measurement then back to plain shutdown
            if (convDone && cfg_q.singleShot && cfg_q.shutdown) cfg_q.singleShot <= 1'b0;
        end
    end

    // conversion timer; one-shot relies on the master setting shutdown first
    assign running = !cfg_q.shutdown || cfg_q.singleShot;
    assign convDone = convCnt_q == 32'(CONV_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (rst) convCnt_q <= 32'h0;
        else if (convDone) convCnt_q <= 32'h0;
        else if (running || convCnt_q != 32'h0) convCnt_q <= convCnt_q + 32'h1;
    end

    assign resMask = res_mask(cfg_q.resolution);
    assign sample = {sensorSync, 4'h0} & resMask;

    // result stored only at conversion end; reads never touch it
    always_ff @(posedge clk) begin
        if (rst) result_q <= tra_pkg::RESULT_RESET;
        else if (convDone) result_q <= sample;
    end

    // thresholds trimmed to the active resolution
    assign overHit = $signed(sample) > $signed(over_q & resMask);
    assign underHit = $signed(sample) < $signed(hyst_q & resMask);
    assign faultNeed = fault_need(cfg_q.faultCount);

    // fault queue counts consecutive qualifying compares toward the next transition
    always_ff @(posedge clk) begin
        if (rst) begin
            faultRun_q <= 3'h0;
            alarm_q <= 1'b0;
            armedHigh_q <= 1'b1;
        end else begin
            // clear first so that a trip in the same cycle wins
            if (cfg_q.intMode && (rdEvent || cfg_q.shutdown)) begin
                alarm_q <= 1'b0;
            end
            if (convDone) begin
                if (armedHigh_q ? overHit : underHit) begin
                    if (faultRun_q + 3'h1 >= faultNeed) begin
                        faultRun_q <= 3'h0;
                        armedHigh_q <= !armedHigh_q;
                        // interrupt mode fires on both crossings; comparator tracks level
                        alarm_q <= cfg_q.intMode ? 1'b1 : armedHigh_q;
                    end else begin
                        faultRun_q <= faultRun_q + 3'h1;
                    end
                end else begin
                    faultRun_q <= 3'h0;
                end
            end
        end
    end

    // driven to the active level while asserted, released otherwise
    assign alarmOut = cfg_q.polarity;
    assign alarmOe_n = !alarm_q;

    always_comb begin
        case (ptrCore)
            tra_pkg::PTR_RESULT: rdWordCore = result_q;
            tra_pkg::PTR_CONFIG: rdWordCore = {cfg_q, 8'h00};
            tra_pkg::PTR_HYST: rdWordCore = hyst_q;
            default: rdWordCore = over_q;
        endcase
    end
endmodule
